// >>> core/rsfs_pkg.sv
// package: register map, field layout and reset values of the ramp spread-spectrum and fault status bank
package rsfs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RSFS_OFS_DITHER_TRI = 8'h6c;
  localparam logic [7:0] RSFS_OFS_FREQ_DIV = 8'h6d;
  localparam logic [7:0] RSFS_OFS_STEP = 8'h6e;
  localparam logic [7:0] RSFS_OFS_AMP_BOUND = 8'h6f;
  localparam logic [7:0] RSFS_OFS_CHANNEL_FAULT_STATUS = 8'h70;
  localparam logic [7:0] RSFS_OFS_GLOBAL_FAULT_STATUS_ONE = 8'h71;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RSFS_RST_DITHER_TRI = 8'h00;
  localparam logic [7:0] RSFS_RST_FREQ_DIV = 8'ha0;
  localparam logic [7:0] RSFS_RST_STEP = 8'h11;
  localparam logic [7:0] RSFS_RST_AMP_BOUND = 8'h24;
  localparam logic [3:0] RSFS_RST_CHANNEL_FAULT_STATUS = 4'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RSFS_TRI_LSB = 0;
  localparam int RSFS_DITHER_LSB = 4;
  localparam int RSFS_RISE_LSB = 0;
  localparam int RSFS_FALL_LSB = 4;
  localparam int RSFS_BOUND_LSB = 0;
  localparam int RSFS_AMP_LSB = 5;
  localparam int RSFS_RIGHT_OC_BIT = 0;
  localparam int RSFS_LEFT_OC_BIT = 1;
  localparam int RSFS_RIGHT_DC_BIT = 2;
  localparam int RSFS_LEFT_DC_BIT = 3;
  localparam int RSFS_EEPROM_ERR_BIT = 5;
  localparam int RSFS_COEF_ERR_BIT = 6;
  localparam int RSFS_OTP_CRC_BIT = 7;

  // manual-mode ramp frequency is this base rate divided by the divisor
  localparam int unsigned RSFS_RAMP_BASE_HZ = 61440000;

endpackage

// >>> core/rsfs_regs.sv
// module: spread-spectrum ramp configuration registers, a sticky channel fault status register and a global fault status register
module rsfs_regs
  import rsfs_pkg::*;
(
  input wire logic clk_i, // 40 MHz device clock
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic [7:0] reg_addr_i, // register offset
  input wire logic reg_wr_i, // one-cycle write strobe
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_rd_i, // one-cycle read strobe
  output logic [7:0] reg_rdata_o, // read data, valid the cycle after reg_rd_i
  input wire logic manual_mode_i, // manual-mode select of the ramp controller
  input wire logic fault_clear_i, // one-cycle pulse: one written to the fault-clear bit
  input wire logic left_dc_fault_i, // left channel DC fault event
  input wire logic right_dc_fault_i, // right channel DC fault event
  input wire logic left_overcurrent_fault_i, // left channel over-current event
  input wire logic right_overcurrent_fault_i, // right channel over-current event
  input wire logic otp_crc_fail_i, // integrity check of the otp memory failed (pulse)
  input wire logic coef_write_done_i, // a coefficient write finished (pulse)
  input wire logic coef_write_ok_i, // outcome of that write, qualified by done
  input wire logic eeprom_load_done_i, // boot load from nonvolatile memory finished (pulse)
  input wire logic eeprom_load_fail_i, // outcome of that load, qualified by done
  output logic [3:0] triangle_ctrl_o, // triangle frequency and range
  output logic [2:0] random_dither_amount_o, // dither amount
  output logic [7:0] manual_freq_divisor_o, // manual divisor, zero outside manual mode
  output logic [3:0] triangle_fall_step_o, // manual fall step, zero outside manual mode
  output logic [3:0] triangle_rise_step_o, // manual rise step, zero outside manual mode
  output logic [1:0] ramp_amplitude_sel_o, // manual amplitude, zero outside manual mode
  output logic [4:0] triangle_period_bound_o, // manual boundary, zero outside manual mode
  output logic output_hiz_o, // output stage forced to high impedance
  output logic fault_pin_o // fault pin, high while any channel fault is latched
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dither_tri;
    logic [7:0] freq_div;
    logic [7:0] step;
    logic [7:0] amp_bound;
    logic [3:0] channel_fault_status;
    logic otp_crc_err;
    logic coef_write_error;
    logic eeprom_err;
    logic [7:0] rdata;
    logic [7:0] man_div;
    logic [3:0] man_fall;
    logic [3:0] man_rise;
    logic [1:0] man_amp;
    logic [4:0] man_bound;
    logic hiz;
  } rsfs_state_t;

  localparam rsfs_state_t RSFS_STATE_RST = '{
    dither_tri: RSFS_RST_DITHER_TRI,
    freq_div: RSFS_RST_FREQ_DIV,
    step: RSFS_RST_STEP,
    amp_bound: RSFS_RST_AMP_BOUND,
    channel_fault_status: RSFS_RST_CHANNEL_FAULT_STATUS,
    default: '0
  };

  rsfs_state_t s_q;
  rsfs_state_t s_d;
  logic [3:0] fault_ev;

  // shared by the write path and the readback mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  assign fault_ev[RSFS_LEFT_DC_BIT] = left_dc_fault_i;
  assign fault_ev[RSFS_RIGHT_DC_BIT] = right_dc_fault_i;
  assign fault_ev[RSFS_LEFT_OC_BIT] = left_overcurrent_fault_i;
  assign fault_ev[RSFS_RIGHT_OC_BIT] = right_overcurrent_fault_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // status registers are read-only: no write case for them
    if (reg_wr_i) begin
      if (hit(reg_addr_i, RSFS_OFS_DITHER_TRI)) s_d.dither_tri = reg_wdata_i;
      if (hit(reg_addr_i, RSFS_OFS_FREQ_DIV)) s_d.freq_div = reg_wdata_i;
      if (hit(reg_addr_i, RSFS_OFS_STEP)) s_d.step = reg_wdata_i;
      if (hit(reg_addr_i, RSFS_OFS_AMP_BOUND)) s_d.amp_bound = reg_wdata_i;
    end
    // a fault in the same cycle as the clear survives it
    if (fault_clear_i) s_d.channel_fault_status = '0;
    s_d.channel_fault_status = s_d.channel_fault_status | fault_ev;
    if (otp_crc_fail_i) s_d.otp_crc_err = 1'b1;
    if (coef_write_done_i) s_d.coef_write_error = !coef_write_ok_i;
    if (eeprom_load_done_i) s_d.eeprom_err = eeprom_load_fail_i;
    s_d.hiz = |s_d.channel_fault_status;
    // manual fields are parked at zero so the ramp ignores them in automatic mode
    s_d.man_div = manual_mode_i ? s_d.freq_div : 8'h00;
    s_d.man_fall = manual_mode_i ? s_d.step[RSFS_FALL_LSB +: 4] : 4'h0;
    s_d.man_rise = manual_mode_i ? s_d.step[RSFS_RISE_LSB +: 4] : 4'h0;
    s_d.man_amp = manual_mode_i ? s_d.amp_bound[RSFS_AMP_LSB +: 2] : 2'h0;
    s_d.man_bound = manual_mode_i ? s_d.amp_bound[RSFS_BOUND_LSB +: 5] : 5'h00;
    // reads only load the data register; no status bit reacts to them
    if (reg_rd_i) begin
      s_d.rdata = 8'h00;
      if (hit(reg_addr_i, RSFS_OFS_DITHER_TRI)) s_d.rdata = s_q.dither_tri;
      if (hit(reg_addr_i, RSFS_OFS_FREQ_DIV)) s_d.rdata = s_q.freq_div;
      if (hit(reg_addr_i, RSFS_OFS_STEP)) s_d.rdata = s_q.step;
      if (hit(reg_addr_i, RSFS_OFS_AMP_BOUND)) s_d.rdata = s_q.amp_bound;
      if (hit(reg_addr_i, RSFS_OFS_CHANNEL_FAULT_STATUS)) s_d.rdata = {4'h0, s_q.channel_fault_status};
      if (hit(reg_addr_i, RSFS_OFS_GLOBAL_FAULT_STATUS_ONE)) begin
        s_d.rdata = 8'h00;
        s_d.rdata[RSFS_OTP_CRC_BIT] = s_q.otp_crc_err;
        s_d.rdata[RSFS_COEF_ERR_BIT] = s_q.coef_write_error;
        s_d.rdata[RSFS_EEPROM_ERR_BIT] = s_q.eeprom_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= RSFS_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign triangle_ctrl_o = s_q.dither_tri[RSFS_TRI_LSB +: 4];
  assign random_dither_amount_o = s_q.dither_tri[RSFS_DITHER_LSB +: 3];
  assign manual_freq_divisor_o = s_q.man_div;
  assign triangle_fall_step_o = s_q.man_fall;
  assign triangle_rise_step_o = s_q.man_rise;
  assign ramp_amplitude_sel_o = s_q.man_amp;
  assign triangle_period_bound_o = s_q.man_bound;
  assign output_hiz_o = s_q.hiz;
  assign fault_pin_o = s_q.hiz;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_div_write;
    reg_wr_i && reg_addr_i == RSFS_OFS_FREQ_DIV && manual_mode_i;
  endsequence

  sequence s_quiet_clear;
    fault_clear_i && fault_ev == 4'h0;
  endsequence

  property p_left_dc;
    @(posedge clk_i) disable iff (!rstn_i)
      left_dc_fault_i |=> s_q.channel_fault_status[3] && output_hiz_o && fault_pin_o;
  endproperty
  a_left_dc: assert property (p_left_dc) else $error("left dc fault not latched");

  property p_right_dc;
    @(posedge clk_i) disable iff (!rstn_i)
      right_dc_fault_i |=> s_q.channel_fault_status[2] && output_hiz_o && fault_pin_o;
  endproperty
  a_right_dc: assert property (p_right_dc) else $error("right dc fault not latched");

  property p_left_oc;
    @(posedge clk_i) disable iff (!rstn_i)
      left_overcurrent_fault_i |=> s_q.channel_fault_status[1] && output_hiz_o && fault_pin_o;
  endproperty
  a_left_oc: assert property (p_left_oc) else $error("left over-current not latched");

  property p_right_oc;
    @(posedge clk_i) disable iff (!rstn_i)
      right_overcurrent_fault_i |=> s_q.channel_fault_status[0] && output_hiz_o && fault_pin_o;
  endproperty
  a_right_oc: assert property (p_right_oc) else $error("right over-current not latched");

  property p_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      s_quiet_clear |=> s_q.channel_fault_status == 4'h0 && !fault_pin_o;
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear did not clear");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !fault_clear_i && fault_pin_o |=> fault_pin_o && (s_q.channel_fault_status & $past(s_q.channel_fault_status)) == $past(s_q.channel_fault_status);
  endproperty
  a_hold: assert property (p_hold) else $error("fault bit dropped without clear");

  property p_otp;
    @(posedge clk_i) disable iff (!rstn_i)
      otp_crc_fail_i |=> s_q.otp_crc_err [*2];
  endproperty
  a_otp: assert property (p_otp) else $error("otp crc error not held");

  property p_coef;
    @(posedge clk_i) disable iff (!rstn_i)
      coef_write_done_i |=> s_q.coef_write_error == !$past(coef_write_ok_i);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient write status wrong");

  property p_eeprom;
    @(posedge clk_i) disable iff (!rstn_i)
      eeprom_load_done_i ##1 reg_rd_i && reg_addr_i == RSFS_OFS_GLOBAL_FAULT_STATUS_ONE
      |=> reg_rdata_o[5] == $past(eeprom_load_fail_i, 2);
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("boot load status wrong");

  property p_manual_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !manual_mode_i |=> manual_freq_divisor_o == 8'h00 && triangle_period_bound_o == 5'h00;
  endproperty
  a_manual_gate: assert property (p_manual_gate) else $error("manual field leaked");

  property p_div_write;
    @(posedge clk_i) disable iff (!rstn_i)
      s_div_write |=> manual_freq_divisor_o == $past(reg_wdata_i);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor write not applied");

  property p_ro_write;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == RSFS_OFS_CHANNEL_FAULT_STATUS && !fault_clear_i && fault_ev == 4'h0
      |=> $stable(s_q.channel_fault_status);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status register took a write");

  // the step and amp/bound write conditions and the left DC fault set are named as sequences
  sequence s_step_write;
    reg_wr_i && reg_addr_i == RSFS_OFS_STEP && manual_mode_i;
  endsequence

  sequence s_amp_write;
    reg_wr_i && reg_addr_i == RSFS_OFS_AMP_BOUND && manual_mode_i;
  endsequence

  sequence s_left_dc_set;
    left_dc_fault_i ##1 !fault_clear_i;
  endsequence

  property p_tri_write;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == RSFS_OFS_DITHER_TRI |=> triangle_ctrl_o == $past(reg_wdata_i[RSFS_TRI_LSB +: 4]);
  endproperty
  a_tri_write: assert property (p_tri_write) else $error("triangle control write not applied");

  property p_dither_write;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == RSFS_OFS_DITHER_TRI
      |=> random_dither_amount_o == $past(reg_wdata_i[RSFS_DITHER_LSB +: 3]);
  endproperty
  a_dither_write: assert property (p_dither_write) else $error("dither write not applied");

  property p_fall_write;
    @(posedge clk_i) disable iff (!rstn_i)
      s_step_write |=> triangle_fall_step_o == $past(reg_wdata_i[RSFS_FALL_LSB +: 4]);
  endproperty
  a_fall_write: assert property (p_fall_write) else $error("fall step write not applied");

  property p_rise_write;
    @(posedge clk_i) disable iff (!rstn_i)
      s_step_write |=> triangle_rise_step_o == $past(reg_wdata_i[RSFS_RISE_LSB +: 4]);
  endproperty
  a_rise_write: assert property (p_rise_write) else $error("rise step write not applied");

  property p_amp_write;
    @(posedge clk_i) disable iff (!rstn_i)
      s_amp_write |=> ramp_amplitude_sel_o == $past(reg_wdata_i[RSFS_AMP_LSB +: 2]);
  endproperty
  a_amp_write: assert property (p_amp_write) else $error("amplitude write not applied");

  property p_bound_write;
    @(posedge clk_i) disable iff (!rstn_i)
      s_amp_write |=> triangle_period_bound_o == $past(reg_wdata_i[RSFS_BOUND_LSB +: 5]);
  endproperty
  a_bound_write: assert property (p_bound_write) else $error("period bound write not applied");

  property p_manual_gate_step;
    @(posedge clk_i) disable iff (!rstn_i)
      !manual_mode_i |=> triangle_fall_step_o == 4'h0 && triangle_rise_step_o == 4'h0 && ramp_amplitude_sel_o == 2'h0;
  endproperty
  a_manual_gate_step: assert property (p_manual_gate_step) else $error("manual step leaked");

  property p_manual_follow;
    @(posedge clk_i) disable iff (!rstn_i)
      manual_mode_i |=> manual_freq_divisor_o == s_q.freq_div;
  endproperty
  a_manual_follow: assert property (p_manual_follow) else $error("divisor not shown in manual mode");

  property p_read_div;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == RSFS_OFS_FREQ_DIV |=> reg_rdata_o == $past(s_q.freq_div);
  endproperty
  a_read_div: assert property (p_read_div) else $error("divisor readback wrong");

  property p_read_chan;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == RSFS_OFS_CHANNEL_FAULT_STATUS |=> reg_rdata_o == {4'h0, $past(s_q.channel_fault_status)};
  endproperty
  a_read_chan: assert property (p_read_chan) else $error("channel status readback wrong");

  // read data must stand until the next read strobe
  property p_rdata_stands;
    @(posedge clk_i) disable iff (!rstn_i)
      !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed without a read");

  property p_read_quiet;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_rd_i && !fault_clear_i && fault_ev == 4'h0 && !otp_crc_fail_i && !coef_write_done_i && !eeprom_load_done_i
      |=> $stable(s_q.channel_fault_status) && $stable({s_q.otp_crc_err, s_q.coef_write_error, s_q.eeprom_err});
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed a status bit");

  property p_ro_global;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == RSFS_OFS_GLOBAL_FAULT_STATUS_ONE && !otp_crc_fail_i && !coef_write_done_i && !eeprom_load_done_i
      |=> $stable({s_q.otp_crc_err, s_q.coef_write_error, s_q.eeprom_err});
  endproperty
  a_ro_global: assert property (p_ro_global) else $error("global status took a write");

  // only reset may drop the integrity error
  property p_otp_sticky;
    @(posedge clk_i) disable iff (!rstn_i)
      s_q.otp_crc_err |=> s_q.otp_crc_err;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky) else $error("otp crc error dropped");

  property p_eeprom_ok;
    @(posedge clk_i) disable iff (!rstn_i)
      eeprom_load_done_i && !eeprom_load_fail_i |=> !s_q.eeprom_err;
  endproperty
  a_eeprom_ok: assert property (p_eeprom_ok) else $error("successful boot load reported as failed");

  property p_fault_hold2;
    @(posedge clk_i) disable iff (!rstn_i)
      s_left_dc_set |=> s_q.channel_fault_status[RSFS_LEFT_DC_BIT] && fault_pin_o;
  endproperty
  a_fault_hold2: assert property (p_fault_hold2) else $error("left dc fault lost without clear");

endmodule

// >>> tb/tb_top.sv
// testbench: register access, manual-mode gating, sticky channel fault status and global fault status of the ramp/fault register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsfs_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic man = 1'b0;
  logic fclr = 1'b0;
  logic [3:0] flt = 4'h0;
  logic otp = 1'b0;
  logic cdone = 1'b0;
  logic cok = 1'b0;
  logic edone = 1'b0;
  logic efail = 1'b0;
  logic [7:0] rdata, div;
  logic [3:0] tri_c, fall, rise;
  logic [2:0] dith;
  logic [1:0] amp;
  logic [4:0] bound;
  logic hiz, pin;
  int num_errors = 0;
  int cmp_count = 0;

  rsfs_regs i_dut (.clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .manual_mode_i(man), .fault_clear_i(fclr),
    .left_dc_fault_i(flt[3]), .right_dc_fault_i(flt[2]), .left_overcurrent_fault_i(flt[1]),
    .right_overcurrent_fault_i(flt[0]), .otp_crc_fail_i(otp), .coef_write_done_i(cdone),
    .coef_write_ok_i(cok), .eeprom_load_done_i(edone), .eeprom_load_fail_i(efail),
    .triangle_ctrl_o(tri_c), .random_dither_amount_o(dith), .manual_freq_divisor_o(div),
    .triangle_fall_step_o(fall), .triangle_rise_step_o(rise), .ramp_amplitude_sel_o(amp),
    .triangle_period_bound_o(bound), .output_hiz_o(hiz), .fault_pin_o(pin));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks; inputs change on the falling edge only
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // read data is registered, so it is settled by the next falling edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp, msg);
  endtask

  task automatic clear_faults();
    @(negedge clk);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang must not hide behind a silent run; the tests need well under 400 cycles
  initial begin
    #(25 * 3000);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    rd_chk(8'h6c, 8'h00, "dither/triangle reset");
    rd_chk(8'h6d, 8'ha0, "divisor reset");
    rd_chk(8'h6e, 8'h11, "step reset");
    rd_chk(8'h6f, 8'h24, "amp/bound reset");
    rd_chk(8'h70, 8'h00, "channel status reset");
    rd_chk(8'h71, 8'h00, "global status reset");
    chk(div, 8'h00, "gated divisor while automatic");
    chk({fall, rise}, 8'h00, "gated steps while automatic");
    man = 1'b1;
    @(negedge clk);
    chk(div, 8'ha0, "divisor output");
    chk({fall, rise}, 8'h11, "step outputs");
    chk({1'b0, amp, bound}, 8'h24, "amp/bound outputs");
    $display("test reset_values done");

    wr_reg(8'h6c, 8'hd7);
    wr_reg(8'h6d, 8'h01);
    wr_reg(8'h6e, 8'hf0);
    wr_reg(8'h6f, 8'hff);
    wr_reg(8'h70, 8'hff);
    wr_reg(8'h71, 8'hff);
    wr_reg(8'h72, 8'h5a);
    chk({1'b0, dith, tri_c}, 8'h57, "dither and triangle outputs");
    chk(div, 8'h01, "divisor minimum");
    chk({fall, rise}, 8'hf0, "fall and rise steps");
    chk({1'b0, amp, bound}, 8'h7f, "amp and bound maxima");
    rd_chk(8'h6c, 8'hd7, "dither/triangle readback");
    rd_chk(8'h6f, 8'hff, "amp/bound readback");
    rd_chk(8'h70, 8'h00, "channel status write ignored");
    rd_chk(8'h71, 8'h00, "global status write ignored");
    rd_chk(8'h72, 8'h00, "unmapped read");
    man = 1'b0;
    @(negedge clk);
    chk(div, 8'h00, "divisor dropped");
    chk({fall, rise}, 8'h00, "steps dropped");
    chk({amp, bound, 1'b0}, 8'h00, "amp/bound dropped");
    chk({4'h0, tri_c}, 8'h07, "triangle control not gated");
    $display("test register_access done");

    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      flt = 4'h1 << i;
      @(negedge clk);
      flt = 4'h0;
      chk({6'h00, hiz, pin}, 8'h03, "hiz and fault pin on fault");
      repeat (3) @(negedge clk);
      chk({6'h00, hiz, pin}, 8'h03, "fault outputs held");
      rd_chk(8'h70, 8'h01 << i, "channel fault bit");
      rd_chk(8'h70, 8'h01 << i, "second read unchanged");
      clear_faults();
      rd_chk(8'h70, 8'h00, "cleared by fault clear");
      chk({6'h00, hiz, pin}, 8'h00, "outputs released after clear");
    end
    @(negedge clk);
    flt = 4'h8;
    fclr = 1'b1;
    @(negedge clk);
    flt = 4'h0;
    fclr = 1'b0;
    rd_chk(8'h70, 8'h08, "fault during clear stays set");
    clear_faults();
    rd_chk(8'h70, 8'h00, "later clear");
    $display("test channel_faults done");

    @(negedge clk);
    otp = 1'b1;
    cdone = 1'b1;
    cok = 1'b0;
    edone = 1'b1;
    efail = 1'b1;
    @(negedge clk);
    {otp, cdone, edone, efail} = 4'h0;
    rd_chk(8'h71, 8'he0, "global error bits");
    clear_faults();
    rd_chk(8'h71, 8'he0, "global bits ignore fault clear");
    chk({7'h00, pin}, 8'h00, "global bits leave fault pin");
    @(negedge clk);
    cdone = 1'b1;
    cok = 1'b1;
    edone = 1'b1;
    @(negedge clk);
    {cdone, cok, edone} = 3'h0;
    rd_chk(8'h71, 8'h80, "successful write and load");
    // read straight after a failed load, so the status is looked at the cycle it lands
    @(negedge clk);
    edone = 1'b1;
    efail = 1'b1;
    @(negedge clk);
    edone = 1'b0;
    efail = 1'b0;
    addr = 8'h71;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, 8'ha0, "failed load read at once");
    $display("test global_faults done");
    conclude();
  end
endmodule
